// File: hdl/pdcpa_pkg.sv
package pdcpa_pkg;
  // clock and timing
  localparam int CLK_KHZ = 125000;
  localparam int CLASS_EVENT_US = 12000;
  localparam int MARK_PAUSE_US = 10000;
  localparam int CLASS_EVENT_CYC = CLASS_EVENT_US * CLK_KHZ / 1000;
  localparam int MARK_PAUSE_CYC = MARK_PAUSE_US * CLK_KHZ / 1000;
  localparam int TMR_W = 21;
  // synchroniser settle before the configuration latch
  localparam logic [1:0] CFG_SETTLE = 2'h2;

  // power level setting, latched on the third clock after reset release
  typedef enum logic [2:0] {
    PM_TYPE1 = 3'h0, PM_TYPE2 = 3'h1, PM_W38 = 3'h2, PM_W52 = 3'h3,
    PM_W70 = 3'h4, PM_W90 = 3'h5, PM_ULTRA = 3'h6
  } pdcpa_mode_t;

  // detection outcomes from the measurement front end
  localparam logic [2:0] DET_UNKNOWN = 3'h0;
  localparam logic [2:0] DET_SHORT = 3'h1;
  localparam logic [2:0] DET_EXCESS_CAP = 3'h2;
  localparam logic [2:0] DET_SIG_LOW = 3'h3;
  localparam logic [2:0] DET_GOOD = 3'h4;
  localparam logic [2:0] DET_SIG_HIGH = 3'h5;
  localparam logic [2:0] DET_OPEN = 3'h6;
  localparam logic [2:0] DET_VOLT_OUT = 3'h7;

  // class measurement codes, 0 to 4 are classes
  localparam logic [2:0] CLS_4 = 3'h4;
  localparam logic [2:0] CLS_OVER = 3'h5;

  // allocation levels
  typedef enum logic [3:0] {
    LVL_NONE = 4'h0, LVL_3W = 4'h1, LVL_7W = 4'h2, LVL_13W = 4'h3, LVL_25W = 4'h4,
    LVL_38W = 4'h5, LVL_52W = 4'h6, LVL_70W = 4'h7, LVL_90W = 4'h8, LVL_MAX = 4'h9,
    LVL_DUAL = 4'ha
  } pdcpa_level_t;

  // cutoff and limit thresholds in mA, indexed by level
  localparam logic [11:0] CUT_MA [0:10] = '{12'h000, 12'h070, 12'h0ce, 12'h177, 12'h27e,
    12'h397, 12'h546, 12'h672, 12'h915, 12'h000, 12'h546};
  localparam logic [11:0] LIM_MA [0:10] = '{12'h000, 12'h1a9, 12'h1a9, 12'h1a9, 12'h352,
    12'h4fb, 12'h5d0, 12'h779, 12'h9f6, 12'hb86, 12'h5d0};
endpackage : pdcpa_pkg

// File: hdl/pdcpa_alloc_if.sv
`timescale 1ns/100ps
interface pdcpa_alloc_if;
  pdcpa_pkg::pdcpa_mode_t mode;
  logic dual;
  pdcpa_pkg::pdcpa_level_t req;
  logic grant;
  pdcpa_pkg::pdcpa_level_t level;
  logic [11:0] cut;
  logic [11:0] lim;
  modport dec (output mode, output dual, output req,
    input grant, input level, input cut, input lim);
  modport alloc (input mode, input dual, input req,
    output grant, output level, output cut, output lim);
endinterface : pdcpa_alloc_if

// File: hdl/pdcpa_alloc.sv
`timescale 1ns/100ps
module pdcpa_alloc (
  pdcpa_alloc_if.alloc a
);
  pdcpa_pkg::pdcpa_level_t cap;

  // ceiling of the selected power setting
  always_comb begin
    case (a.mode)
      pdcpa_pkg::PM_TYPE1: cap = pdcpa_pkg::LVL_13W;
      pdcpa_pkg::PM_TYPE2: cap = pdcpa_pkg::LVL_25W;
      pdcpa_pkg::PM_W38: cap = pdcpa_pkg::LVL_38W;
      pdcpa_pkg::PM_W52: cap = pdcpa_pkg::LVL_52W;
      pdcpa_pkg::PM_W70: cap = pdcpa_pkg::LVL_70W;
      pdcpa_pkg::PM_W90: cap = pdcpa_pkg::LVL_90W;
      default: cap = pdcpa_pkg::LVL_MAX;
    endcase
  end

  // compare requested level with the ceiling
  always_comb begin
    a.grant = (a.req != pdcpa_pkg::LVL_NONE) || a.dual;
    a.level = a.req;
    if (a.mode == pdcpa_pkg::PM_ULTRA) begin
      a.level = pdcpa_pkg::LVL_MAX;
    end else if (a.dual) begin
      a.level = pdcpa_pkg::LVL_DUAL;
    end else if (a.mode == pdcpa_pkg::PM_TYPE1 || a.mode == pdcpa_pkg::PM_TYPE2) begin
      if (a.req > cap) begin
        a.level = cap;
      end
    end else if (a.req > cap) begin
      a.grant = 1'b0;
      a.level = pdcpa_pkg::LVL_NONE;
    end
    a.cut = pdcpa_pkg::CUT_MA[a.level];
    a.lim = pdcpa_pkg::LIM_MA[a.level];
  end
endmodule : pdcpa_alloc

// File: hdl/pdcpa_top.sv
`timescale 1ns/100ps
module pdcpa_top #(
  parameter int CLASS_CYC = pdcpa_pkg::CLASS_EVENT_CYC,
  parameter int MARK_CYC = pdcpa_pkg::MARK_PAUSE_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [2:0] power_level_select,
  input wire logic legacy_enable,
  input wire logic midspan_enable,
  input wire logic twin_signature_enable,
  input wire logic detect_done,
  input wire logic [2:0] detect_result,
  input wire logic [2:0] class_code,
  input wire logic power_release,
  output logic config_ready,
  output logic midspan_mode,
  output logic classification_voltage_window,
  output logic mark_voltage_on,
  output logic power_grant,
  output logic power_deny,
  output logic detect_restart,
  output logic dual_signature_active,
  output logic [3:0] alloc_level,
  output logic [11:0] cutoff_threshold,
  output logic [11:0] limit_threshold
);
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_CLASS = 3'h1, S_MARK = 3'h2, S_DECIDE = 3'h3, S_POWER = 3'h4
  } pdcpa_fsm_t;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [1:0] settle;
    logic cfg_ready;
    pdcpa_pkg::pdcpa_mode_t mode;
    logic legacy;
    logic mid;
    logic twin;
    pdcpa_fsm_t fsm;
    logic [pdcpa_pkg::TMR_W-1:0] tmr;
    logic [1:0] evt;
    logic twin_path;
    logic [2:0] c1;
    pdcpa_pkg::pdcpa_level_t req;
    logic dual;
    logic cv;
    logic mark;
    logic grant;
    logic deny;
    logic restart;
    pdcpa_pkg::pdcpa_level_t lvl;
    logic [11:0] cut;
    logic [11:0] lim;
  } pdcpa_top_state_t;

  pdcpa_top_state_t st;
  pdcpa_top_state_t next_st;
  pdcpa_alloc_if ai ();
  logic det_ok;

  pdcpa_alloc u_alloc (.a(ai));

  // decision inputs to the allocator
  assign ai.mode = st.mode;
  assign ai.dual = st.dual;
  assign ai.req = st.req;

  // detection acceptance
  always_comb begin
    det_ok = (detect_result == pdcpa_pkg::DET_GOOD);
    if (st.legacy && (detect_result == pdcpa_pkg::DET_EXCESS_CAP ||
        detect_result == pdcpa_pkg::DET_SIG_LOW || detect_result == pdcpa_pkg::DET_SIG_HIGH)) begin
      det_ok = 1'b1;
    end
    if (st.twin && detect_result == pdcpa_pkg::DET_SIG_LOW) begin
      det_ok = 1'b1;
    end
  end

  // next state
  always_comb begin
    logic bad;
    logic more;
    pdcpa_pkg::pdcpa_level_t lv;
    bad = 1'b0;
    more = 1'b0;
    lv = pdcpa_pkg::LVL_NONE;
    next_st = st;
    next_st.sync1 = {power_level_select, legacy_enable, midspan_enable, twin_signature_enable};
    next_st.sync2 = st.sync1;
    next_st.deny = 1'b0;
    next_st.restart = 1'b0;
    if (!st.cfg_ready) begin
      if (st.settle == pdcpa_pkg::CFG_SETTLE) begin
        next_st.cfg_ready = 1'b1;
        next_st.mode = (st.sync2[5:3] == 3'h7) ? pdcpa_pkg::PM_TYPE1
          : pdcpa_pkg::pdcpa_mode_t'(st.sync2[5:3]);
        next_st.legacy = st.sync2[2];
        next_st.mid = st.sync2[1];
        next_st.twin = st.sync2[0];
      end else begin
        next_st.settle = st.settle + 2'h1;
      end
    end
    case (st.fsm)
      S_IDLE: begin
        if (st.cfg_ready && detect_done) begin
          if (det_ok) begin
            next_st.cv = 1'b1;
            next_st.tmr = pdcpa_pkg::TMR_W'(CLASS_CYC - 1);
            next_st.evt = 2'h0;
            next_st.twin_path = st.twin && detect_result == pdcpa_pkg::DET_SIG_LOW;
            next_st.dual = 1'b0;
            next_st.fsm = S_CLASS;
          end else begin
            next_st.restart = 1'b1;
          end
        end
      end
      S_CLASS: begin
        if (st.tmr != '0) begin
          next_st.tmr = st.tmr - 1'b1;
        end else begin
          next_st.cv = 1'b0;
          case (st.evt)
            2'h0: begin
              if (class_code < pdcpa_pkg::CLS_4) begin
                case (class_code)
                  3'h1: lv = pdcpa_pkg::LVL_3W;
                  3'h2: lv = pdcpa_pkg::LVL_7W;
                  default: lv = pdcpa_pkg::LVL_13W;
                endcase
                if (st.legacy) begin
                  lv = pdcpa_pkg::LVL_13W;
                end
              end else if (class_code == pdcpa_pkg::CLS_4) begin
                // single event only at Type 1
                if (st.mode == pdcpa_pkg::PM_TYPE1) begin
                  lv = pdcpa_pkg::LVL_25W;
                end else begin
                  more = 1'b1;
                end
              end else if (class_code == pdcpa_pkg::CLS_OVER && st.twin_path &&
                  st.mode != pdcpa_pkg::PM_TYPE1) begin
                more = 1'b1;
              end else begin
                bad = 1'b1;
              end
            end
            2'h1: begin
              if (st.c1 == pdcpa_pkg::CLS_OVER) begin
                bad = (class_code != pdcpa_pkg::CLS_OVER);
                next_st.dual = !bad;
              end else if (class_code == pdcpa_pkg::CLS_4) begin
                if (st.mode >= pdcpa_pkg::PM_W38) begin
                  more = 1'b1;
                end else begin
                  lv = pdcpa_pkg::LVL_25W;
                end
              end else begin
                // class 4 then any code other than class 4 is invalid
                bad = 1'b1;
              end
            end
            default: begin
              case (class_code)
                3'h0: lv = pdcpa_pkg::LVL_38W;
                3'h1: lv = pdcpa_pkg::LVL_52W;
                3'h2: lv = pdcpa_pkg::LVL_70W;
                3'h3: lv = pdcpa_pkg::LVL_90W;
                3'h4: lv = pdcpa_pkg::LVL_25W;
                default: bad = 1'b1;
              endcase
            end
          endcase
          if (st.evt == 2'h0) begin
            next_st.c1 = class_code;
          end
          if (bad) begin
            next_st.deny = 1'b1;
            next_st.restart = 1'b1;
            next_st.fsm = S_IDLE;
          end else if (more) begin
            next_st.mark = 1'b1;
            next_st.tmr = pdcpa_pkg::TMR_W'(MARK_CYC - 1);
            next_st.fsm = S_MARK;
          end else begin
            next_st.req = lv;
            next_st.fsm = S_DECIDE;
          end
        end
      end
      S_MARK: begin
        if (st.tmr != '0) begin
          next_st.tmr = st.tmr - 1'b1;
        end else begin
          next_st.mark = 1'b0;
          next_st.cv = 1'b1;
          next_st.tmr = pdcpa_pkg::TMR_W'(CLASS_CYC - 1);
          next_st.evt = st.evt + 2'h1;
          next_st.fsm = S_CLASS;
        end
      end
      S_DECIDE: begin
        if (ai.grant) begin
          next_st.grant = 1'b1;
          next_st.lvl = ai.level;
          next_st.cut = ai.cut;
          next_st.lim = ai.lim;
          next_st.fsm = S_POWER;
        end else begin
          next_st.deny = 1'b1;
          next_st.restart = 1'b1;
          next_st.dual = 1'b0;
          next_st.fsm = S_IDLE;
        end
      end
      S_POWER: begin
        if (power_release) begin
          next_st.grant = 1'b0;
          next_st.dual = 1'b0;
          next_st.lvl = pdcpa_pkg::LVL_NONE;
          next_st.cut = '0;
          next_st.lim = '0;
          next_st.fsm = S_IDLE;
        end
      end
      default: next_st.fsm = S_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign config_ready = st.cfg_ready;
  assign midspan_mode = st.mid;
  assign classification_voltage_window = st.cv;
  assign mark_voltage_on = st.mark;
  assign power_grant = st.grant;
  assign power_deny = st.deny;
  assign detect_restart = st.restart;
  assign dual_signature_active = st.dual && st.grant;
  assign alloc_level = st.lvl;
  assign cutoff_threshold = st.cut;
  assign limit_threshold = st.lim;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  cfg_hold_a: assert property (st.cfg_ready && $past(st.cfg_ready) |->
    $stable({st.mode, st.legacy, st.mid, st.twin})) else $error("config changed");
  good_start_a: assert property (st.fsm == S_IDLE && st.cfg_ready && detect_done &&
    detect_result == pdcpa_pkg::DET_GOOD |=> classification_voltage_window)
    else $error("good signature not classified");
  strict_reject_a: assert property (st.fsm == S_IDLE && detect_done && !st.legacy &&
    st.cfg_ready && !st.twin && detect_result != pdcpa_pkg::DET_GOOD |=>
    !classification_voltage_window &&
    detect_restart) else $error("bad signature accepted");
  legacy_accept_a: assert property (st.fsm == S_IDLE && st.cfg_ready && detect_done &&
    st.legacy && detect_result == pdcpa_pkg::DET_EXCESS_CAP |=> classification_voltage_window)
    else $error("legacy outcome rejected");
  twin_low_a: assert property (st.fsm == S_IDLE && st.cfg_ready && detect_done &&
    st.twin && detect_result == pdcpa_pkg::DET_SIG_LOW |=> classification_voltage_window)
    else $error("twin low signature rejected");
  mark_then_class_a: assert property ($fell(mark_voltage_on) && st.cfg_ready |->
    classification_voltage_window) else $error("no class event after mark");
  type1_single_a: assert property (st.mode == pdcpa_pkg::PM_TYPE1 |->
    !mark_voltage_on) else $error("second event at type 1");
  legacy_13w_a: assert property ($rose(power_grant) && st.legacy && st.evt == 2'h0 &&
    st.c1 < pdcpa_pkg::CLS_4 && st.mode != pdcpa_pkg::PM_ULTRA |->
    alloc_level == pdcpa_pkg::LVL_13W) else $error("legacy allocation wrong");
  type1_cap_a: assert property (power_grant && st.mode == pdcpa_pkg::PM_TYPE1 |->
    alloc_level <= pdcpa_pkg::LVL_13W) else $error("type 1 ceiling broken");
  type2_cap_a: assert property (power_grant && st.mode == pdcpa_pkg::PM_TYPE2 && !st.dual
    |-> alloc_level <= pdcpa_pkg::LVL_25W) else $error("type 2 ceiling broken");
  ultra_max_a: assert property ($rose(power_grant) && st.mode == pdcpa_pkg::PM_ULTRA |->
    alloc_level == pdcpa_pkg::LVL_MAX && limit_threshold == pdcpa_pkg::LIM_MA[9])
    else $error("override not at maximum");
  restart_unpowered_a: assert property (detect_restart |-> !power_grant &&
    st.fsm == S_IDLE) else $error("restart while powered");

  grant_seen_c: cover property ($rose(power_grant));
  deny_seen_c: cover property (power_deny && st.evt == 2'h1);
  third_event_c: cover property ($rose(classification_voltage_window) && st.evt == 2'h2);
  dual_seen_c: cover property ($rose(dual_signature_active));
endmodule : pdcpa_top

// File: verification/pdcpa_pd_model.sv
`timescale 1ns/100ps
module pdcpa_pd_model (
  input wire logic ref_clk,
  input wire logic start,
  input wire logic [2:0] det,
  input wire logic [2:0] cls0,
  input wire logic [2:0] cls1,
  input wire logic [2:0] cls2,
  input wire logic window,
  output logic detect_done,
  output logic [2:0] detect_result,
  output logic [2:0] class_code
);
  logic [1:0] ev;
  logic [2:0] noise = 3'h0;
  // one-cycle detection report after a start request
  always @(posedge ref_clk) begin
    detect_done <= #1 start;
    detect_result <= #1 start ? det : ~det ^ noise; // junk outside the pulse
    noise <= noise + 3'h3;
  end
  // count finished class events, cleared per detection
  always @(negedge window or posedge start) begin
    if (start) begin
      ev <= 2'h0;
    end else begin
      ev <= ev + 2'h1;
    end
  end
  // load current only while the class voltage is applied
  assign class_code = !window ? noise : (ev == 2'h0) ? cls0 : (ev == 2'h1) ? cls1 : cls2;
endmodule : pdcpa_pd_model

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
  localparam int CC = 8;
  localparam int MC = 4;
  logic ref_clk, resetn, legacy_enable, midspan_enable, twin_signature_enable;
  logic power_release, start, tw, detect_done, config_ready, midspan_mode;
  logic [2:0] power_level_select, det, cls0, cls1, cls2, detect_result, class_code;
  logic [2:0] m, d, a, b, c;
  logic classification_voltage_window, mark_voltage_on, power_grant, power_deny;
  logic detect_restart, dual_signature_active;
  logic [3:0] alloc_level;
  logic [11:0] cutoff_threshold, limit_threshold;
  logic [31:0] r;
  int failures, check_count;

  pdcpa_top #(.CLASS_CYC(CC), .MARK_CYC(MC)) uut (.ref_clk, .resetn, .power_level_select,
    .legacy_enable, .midspan_enable, .twin_signature_enable, .detect_done, .detect_result,
    .class_code, .power_release, .config_ready, .midspan_mode, .classification_voltage_window,
    .mark_voltage_on, .power_grant, .power_deny, .detect_restart, .dual_signature_active,
    .alloc_level, .cutoff_threshold, .limit_threshold);

  pdcpa_pd_model pm (.ref_clk, .start, .det, .cls0, .cls1, .cls2,
    .window(classification_voltage_window), .detect_done, .detect_result, .class_code);

  // free-running clock
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  // next pseudo-random word
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'h0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  // expected {events, deny, level} for one load
  function automatic logic [6:0] expect_out(input logic [2:0] m, input logic lg, tw,
      input logic [2:0] d, a, b, c);
    logic [2:0] mm;
    logic [3:0] lv;
    logic lo;
    mm = (m == 3'h7) ? 3'h0 : m;
    lo = d == pdcpa_pkg::DET_SIG_LOW;
    if (d != pdcpa_pkg::DET_GOOD && !(tw && lo) && !(lg && (lo ||
        d == pdcpa_pkg::DET_EXCESS_CAP || d == pdcpa_pkg::DET_SIG_HIGH))) return 7'h00;
    if (mm == 3'h6) return {3'h2, pdcpa_pkg::LVL_MAX};
    if (a < 3'h4) return {3'h2, (lg || a == 3'h0 || a == 3'h3) ? 4'h3 : {2'h0, a[1:0]}};
    if (a == 3'h4 && mm == 3'h0) return {3'h2, pdcpa_pkg::LVL_13W};
    if (mm == 3'h0 || a > 3'h5 || (a == 3'h5 && !(tw && lo))) return 7'h30;
    if (a == 3'h5) return (b == 3'h5) ? {3'h4, pdcpa_pkg::LVL_DUAL} : 7'h50;
    if (b != 3'h4) return 7'h50;
    if (mm == 3'h1) return {3'h4, pdcpa_pkg::LVL_25W};
    lv = (c == 3'h4) ? 4'h4 : 4'h5 + {1'h0, c};
    return (lv > 4'h3 + {1'h0, mm}) ? 7'h70 : {3'h6, lv};
  endfunction : expect_out

  // expected {cutoff, limit} in mA for a granted level
  function automatic logic [23:0] thr(input logic [3:0] lv);
    case (lv)
      4'h1: return 24'h0701a9;
      4'h2: return 24'h0ce1a9;
      4'h3: return 24'h1771a9;
      4'h4: return 24'h27e352;
      4'h5: return 24'h3974fb;
      4'h6, 4'ha: return 24'h5465d0;
      4'h7: return 24'h672779;
      4'h8: return 24'h9159f6;
      4'h9: return 24'h000b86;
      default: return 24'h0;
    endcase
  endfunction : thr

  task automatic check(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  // one reset, detection and classification pass with a given load
  task automatic run_trial(input logic [2:0] m, input logic lg, md, tw,
      input logic [2:0] d, a, b, c);
    logic [6:0] e;
    logic sg, sd, sr;
    int win, mrk, i, last;
    e = expect_out(m, lg, tw, d, a, b, c);
    resetn = 1'h0;
    {power_level_select, legacy_enable, midspan_enable, twin_signature_enable} = {m, lg, md, tw};
    {det, cls0, cls1, cls2} = {d, a, b, c};
    repeat (2) tick;
    resetn = 1'h1;
    for (i = 0; i < 20 && config_ready !== 1'h1; i++) tick;
    if (i == 20) begin
      failures++;
      stop_test;
    end
    check(midspan_mode, md);
    {power_level_select, legacy_enable, midspan_enable, twin_signature_enable} = ~{m, lg, md, tw};
    start = 1'h1;
    tick;
    start = 1'h0;
    sg = 1'h0;
    sd = 1'h0;
    sr = 1'h0;
    win = 0;
    mrk = 0;
    last = 300;
    for (i = 0; i <= last && !sg; i++) begin
      tick;
      win += classification_voltage_window;
      mrk += mark_voltage_on;
      sg |= power_grant === 1'h1;
      sd |= power_deny === 1'h1;
      if (detect_restart === 1'h1 && !sr) begin
        sr = 1'h1;
        last = i + 2;
      end
    end
    if (!sg && !sr) begin
      failures++;
      stop_test;
    end
    check(midspan_mode, md);
    check({sg, sd, sr}, {e[3:0] != 4'h0, e[4], e[3:0] == 4'h0});
    if (m != 3'h6) begin
      check(win, e[6:5] * CC);
      check(mrk, (e[6:5] == 2'h0) ? 0 : (e[6:5] - 1) * MC);
    end
    if (sg) begin
      check(alloc_level, e[3:0]);
      check({cutoff_threshold, limit_threshold}, thr(e[3:0]));
      check(dual_signature_active, e[3:0] == 4'ha);
      power_release = 1'h1;
      tick;
      power_release = 1'h0;
      check({power_grant, alloc_level, cutoff_threshold, limit_threshold}, 0);
    end
  endtask : run_trial

  // reset, corner cases, then random loads
  initial begin
    r = 32'he5a36e81;
    failures = 0;
    check_count = 0;
    {resetn, power_release, start, legacy_enable, midspan_enable, twin_signature_enable} = '0;
    {power_level_select, det, cls0, cls1, cls2} = '0;
    repeat (12) tick;
    run_trial(3'h0, 1'h0, 1'h0, 1'h0, 3'h4, 3'h4, 3'h4, 3'h0);
    run_trial(3'h1, 1'h0, 1'h1, 1'h0, 3'h4, 3'h4, 3'h4, 3'h0);
    run_trial(3'h1, 1'h0, 1'h0, 1'h0, 3'h4, 3'h4, 3'h2, 3'h0);
    run_trial(3'h4, 1'h0, 1'h0, 1'h0, 3'h4, 3'h4, 3'h4, 3'h3);
    run_trial(3'h2, 1'h0, 1'h0, 1'h0, 3'h4, 3'h4, 3'h4, 3'h1);
    run_trial(3'h4, 1'h0, 1'h1, 1'h0, 3'h4, 3'h4, 3'h4, 3'h2);
    run_trial(3'h5, 1'h0, 1'h0, 1'h0, 3'h4, 3'h4, 3'h4, 3'h4);
    run_trial(3'h2, 1'h0, 1'h0, 1'h1, 3'h3, 3'h5, 3'h5, 3'h0);
    run_trial(3'h0, 1'h1, 1'h0, 1'h0, 3'h2, 3'h1, 3'h0, 3'h0);
    run_trial(3'h1, 1'h0, 1'h0, 1'h0, 3'h5, 3'h1, 3'h0, 3'h0);
    run_trial(3'h6, 1'h0, 1'h0, 1'h0, 3'h4, 3'h2, 3'h0, 3'h0);
    run_trial(3'h1, 1'h0, 1'h0, 1'h0, 3'h4, 3'h0, 3'h0, 3'h0);
    run_trial(3'h7, 1'h0, 1'h0, 1'h0, 3'h4, 3'h1, 3'h0, 3'h0);
    run_trial(3'h2, 1'h0, 1'h0, 1'h0, 3'h4, 3'h6, 3'h0, 3'h0);
    for (int n = 0; n < 80; n++) begin
      r = lfsr(r);
      {m, tw, d} = {r[2:0], r[5], r[8:6]};
      a = (r[11:9] < 3'h4) ? {1'h0, r[10:9]} : (r[11:9] == 3'h7) ? 3'h6 : 3'h4;
      if (r[11:9] == 3'h6 && tw && d == pdcpa_pkg::DET_SIG_LOW && m != 3'h0 && m != 3'h7) a = 3'h5;
      if (m == 3'h6) a = {1'h0, r[10:9]};
      b = (r[13:12] == 3'h2) ? 3'h5 : (r[13:12] == 3'h3) ? 3'h2 : 3'h4;
      c = r[16:14] % 3'h5;
      run_trial(m, r[3], r[4], tw, d, a, b, c);
    end
    stop_test;
  end
endmodule : tb
